// ===== design/bes_booster_supervisor.sv
// Booster enable supervisor with buck off-time timers
`timescale 1ns/1ps
`default_nettype none
module bes_booster_supervisor #(
  parameter int unsigned NCH    = 2,   // buck channels
  parameter int unsigned ACC_W  = 16,  // off-time accumulator
  parameter int unsigned TSCALE = 256  // off-time per factor step
) (
  input  wire logic                         core_clk_i,     // 10 MHz
  input  wire logic                         rst_n_i,        // async
  input  wire logic [bes_pkg::ADDR_W-1:0]   addr_i,         // reg addr
  input  wire logic [bes_pkg::DATA_W-1:0]   wdata_i,        // write data
  input  wire logic                         wr_i,           // write
  input  wire logic                         rd_i,           // read
  output logic      [bes_pkg::DATA_W-1:0]   rdata_o,        // read data
  input  wire logic                         ov_trip_i,      // OV comp
  input  wire logic                         below_react_i,  // under hyst
  input  wire logic                         comp_below_i,   // skip comp
  input  wire logic                         external_phase_clock_i, // sync
  input  wire logic [3:0]                   factory_trim_i, // fuses
  input  wire logic [NCH*8-1:0]             vled_code_i,    // LED volts
  input  wire logic [NCH-1:0]               buck_off_start_i, // off begin
  output logic      [NCH-1:0]               buck_off_done_o,  // off end
  output logic                              booster_run_o,  // enable
  output logic                              gate_pulse_o,   // sw edge
  output logic      [1:0]                   pulse_skip_level_o, // thr
  output logic      [1:0]                   error_amp_gain_o,   // gm
  output logic      [1:0]                   multi_phase_select_o, // mode
  output logic                              overvoltage_flag_o, // latched
  output logic                              irq_o           // interrupt
);
  import bes_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [3:0]         s1;
    logic [3:0]         s2;
    logic [3:0]         s3;
    logic [3:0]         filt;
    logic               run_req;
    logic               sync_edge_invert;
    logic [1:0]         pulse_skip_level;
    logic [1:0]         error_amp_gain;
    logic [1:0]         multi_phase_select;
    logic [6:0]         boost_voltage_target;
    logic [3:0]         overvoltage_shutdown_margin;
    logic [NCH*4-1:0]   off_time_factor;
    logic [3:0]         factory_limit_trim;
    logic               trim_loaded;
    logic               overvoltage_flag;
    logic               ov_halt;
    logic               limit_ok;
    logic               active;
    logic [2:0]         irq_stat;
    logic [2:0]         irq_mask;
    logic               gate_pulse;
    logic [NCH-1:0]     off_busy;
    logic [NCH-1:0]     off_done;
    logic [NCH*ACC_W-1:0] off_acc;
    logic [DATA_W-1:0]  rdata;
  } bes_state_t;

  bes_state_t q;
  bes_state_t d;
  logic               ext_edge;
  logic               skip_now;
  logic [2:0]         irq_ev;
  logic [ACC_W:0]     off_sum [NCH];
  logic [ACC_W:0]     off_tgt [NCH];
  logic [7:0]         vstep   [NCH];

  // ------------------------------------------------------------
  // Limit relation
  // ------------------------------------------------------------
  // Both sides stay positive for every code, so no sign is needed
  function automatic logic limit_ok_f(input logic [6:0] sp,
                                      input logic [3:0] mg,
                                      input logic [3:0] tr);
    logic [11:0] lhs;
    logic [11:0] rhs;
    logic [11:0] adj;
    lhs = SP_BASE_DV - (SP_MAX_CODE - {5'h00, sp}) * SP_STEP_DV;
    lhs = lhs + {8'h00, mg} * OV_STEP_DV;
    adj = {9'h000, tr[2:0]} * TRIM_ST_DV;
    rhs = tr[3] ? LIM_BASE_DV - adj : LIM_BASE_DV + adj;
    return lhs > rhs;
  endfunction

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    d = q;
    d.gate_pulse = 1'b0;
    d.off_done = '0;
    d.rdata = '0;
    ext_edge = 1'b0;
    skip_now = 1'b0;
    irq_ev = '0;
    // Three-stage synchronisers, change taken when stages agree
    d.s1 = {comp_below_i, external_phase_clock_i, below_react_i, ov_trip_i};
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < 4; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.filt[i] = q.s3[i];
      end
    end
    // fuse value caught once after reset
    if (!q.trim_loaded) begin
      d.factory_limit_trim = factory_trim_i;
      d.trim_loaded = 1'b1;
    end
    // Register writes
    if (wr_i) begin
      case (addr_i)
        REG_CTRL: begin
          d.run_req = wdata_i[0];
          d.sync_edge_invert = wdata_i[1];
          d.pulse_skip_level = wdata_i[3:2];
          d.error_amp_gain = wdata_i[5:4];
          d.multi_phase_select = wdata_i[7:6];
        end
        REG_SETPT: begin
          d.boost_voltage_target = wdata_i[6:0];
          d.overvoltage_shutdown_margin = wdata_i[11:8];
        end
        REG_TOFF: d.off_time_factor = wdata_i[NCH*4-1:0];
        REG_IRQS: d.irq_stat = q.irq_stat & ~wdata_i[2:0];
        REG_IRQM: d.irq_mask = wdata_i[2:0];
        default: ;
      endcase
    end
    // halt on overvoltage, resume under hysteresis
    if (d.filt[LN_OV]) begin
      d.ov_halt = 1'b1;
    end else if (d.filt[LN_RE]) begin
      d.ov_halt = 1'b0;
    end
    // read below reactivation clears, a new trip wins
    if (rd_i && addr_i == REG_STAT && d.filt[LN_RE]) begin
      d.overvoltage_flag = 1'b0;
    end
    if (d.filt[LN_OV]) begin
      d.overvoltage_flag = 1'b1;
    end
    d.limit_ok = limit_ok_f(d.boost_voltage_target,
                            d.overvoltage_shutdown_margin,
                            d.factory_limit_trim);
    // running only when requested, safe and not halted
    d.active = d.run_req & d.limit_ok & ~d.ov_halt;
    // edge selection on the sync input
    ext_edge = q.sync_edge_invert ? (q.filt[LN_EX] & ~d.filt[LN_EX])
                                  : (~q.filt[LN_EX] & d.filt[LN_EX]);
    // skip only with a nonzero level and low compensation node
    skip_now = (q.pulse_skip_level != SKIP_OFF) & d.filt[LN_SK];
    d.gate_pulse = q.active & ~skip_now & ext_edge;
    // accumulate LED voltage until factor target is reached
    for (int c = 0; c < NCH; c++) begin
      vstep[c] = (vled_code_i[c*8 +: 8] == 8'h00) ? 8'h01
                                                  : vled_code_i[c*8 +: 8];
      off_sum[c] = {1'b0, q.off_acc[c*ACC_W +: ACC_W]}
                 + {{(ACC_W-7){1'b0}}, vstep[c]};
      off_tgt[c] = (ACC_W+1)'(({1'b0, q.off_time_factor[c*4 +: 4]} + 5'h01)
                 * TSCALE);
      if (buck_off_start_i[c]) begin
        d.off_acc[c*ACC_W +: ACC_W] = '0;
        d.off_busy[c] = 1'b1;
      end else if (q.off_busy[c]) begin
        if (off_sum[c] >= off_tgt[c]) begin
          d.off_busy[c] = 1'b0;
          d.off_done[c] = 1'b1;
        end else begin
          d.off_acc[c*ACC_W +: ACC_W] = off_sum[c][ACC_W-1:0];
        end
      end
    end
    // Sticky events, set wins over a clearing write
    irq_ev[0] = d.filt[LN_OV] & ~q.filt[LN_OV];
    irq_ev[1] = q.limit_ok & ~d.limit_ok;
    irq_ev[2] = d.active ^ q.active;
    d.irq_stat = d.irq_stat | irq_ev;
    // Read data for the cycle after the strobe
    if (rd_i) begin
      case (addr_i)
        REG_CTRL: d.rdata = {8'h00, q.multi_phase_select,
                             q.error_amp_gain, q.pulse_skip_level,
                             q.sync_edge_invert, q.run_req};
        REG_SETPT: d.rdata = {4'h0, q.overvoltage_shutdown_margin,
                              1'b0, q.boost_voltage_target};
        REG_TOFF: d.rdata = DATA_W'(q.off_time_factor);
        REG_STAT: d.rdata = {4'h0, q.factory_limit_trim, 4'h0,
                             q.ov_halt, q.limit_ok,
                             q.overvoltage_flag, q.active};
        REG_IRQS: d.rdata = {13'h0000, q.irq_stat};
        REG_IRQM: d.rdata = {13'h0000, q.irq_mask};
        default: d.rdata = '0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
      q.sync_edge_invert <= EDGE_INV_RST;
      q.multi_phase_select <= MP_SEL_RST;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from flops, irq is a level of the status and mask flops
  assign rdata_o              = q.rdata;
  assign booster_run_o        = q.active;
  assign gate_pulse_o         = q.gate_pulse;
  assign buck_off_done_o      = q.off_done;
  assign pulse_skip_level_o   = q.pulse_skip_level;
  assign error_amp_gain_o     = q.error_amp_gain;
  assign multi_phase_select_o = q.multi_phase_select;
  assign overvoltage_flag_o   = q.overvoltage_flag;
  assign irq_o                = |(q.irq_stat & q.irq_mask);

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_STOP_ON_CLEAR: assert property (
    $fell(q.run_req) |-> !booster_run_o)
    else $error("booster runs after request cleared");
  AST_START_ON_SET: assert property (
    $rose(q.run_req) && q.limit_ok && !q.ov_halt |-> booster_run_o)
    else $error("booster did not start on request");
  AST_STATUS_READ: assert property (
    rd_i && addr_i == REG_STAT |=> rdata_o[0] == $past(q.active))
    else $error("status bit differs from activity");
  AST_OV_HALT: assert property (
    q.filt[LN_OV] |-> !booster_run_o && q.ov_halt)
    else $error("booster not halted on overvoltage");
  // Below reactivation with no trip the request and the limit decide
  AST_OV_RESUME: assert property (
    q.filt[LN_RE] && !q.filt[LN_OV] && q.run_req && q.limit_ok
      |-> booster_run_o && !q.ov_halt)
    else $error("booster did not resume below hysteresis");
  // Halt must hold while the synchronised level is still above
  AST_HALT_HOLD: assert property (
    q.ov_halt && !q.filt[LN_RE] && !q.s3[LN_RE] |=> q.ov_halt)
    else $error("halt released above reactivation level");
  AST_LIMIT_BLOCK: assert property (
    !q.limit_ok |-> !booster_run_o)
    else $error("booster runs with unsafe setpoint");
  AST_TRIM_STABLE: assert property (
    q.trim_loaded |=> $stable(q.factory_limit_trim))
    else $error("trim changed after capture");
  AST_SKIP_BLOCK: assert property (
    gate_pulse_o |-> !($past(q.pulse_skip_level) != SKIP_OFF
                       && q.filt[LN_SK]))
    else $error("pulse passed while skipping");
  AST_EDGE_SEL: assert property (
    gate_pulse_o |-> $past(q.filt[LN_EX]) != q.filt[LN_EX]
      && q.filt[LN_EX] == !$past(q.sync_edge_invert))
    else $error("gate pulse on wrong sync edge");
  AST_OFF_DONE: assert property (
    buck_off_done_o[0] |-> $past(q.off_busy[0]) && !q.off_busy[0])
    else $error("off-time end without running timer");
  AST_FLAG_LATCH: assert property (
    q.overvoltage_flag && !(rd_i && addr_i == REG_STAT) |=>
      q.overvoltage_flag)
    else $error("overvoltage flag dropped without read");
  AST_FLAG_SET: assert property (
    q.filt[LN_OV] |-> q.overvoltage_flag)
    else $error("overvoltage flag not set on trip");
  // Cause is latched on the trip even against a clearing write
  AST_IRQ_STICKY: assert property (
    q.filt[LN_OV] && !$past(q.filt[LN_OV]) |-> q.irq_stat[0])
    else $error("overvoltage cause not latched");
  // Gate pulses only from a running booster, one cycle each
  AST_GATE_NEEDS_RUN: assert property (
    gate_pulse_o |-> $past(q.active))
    else $error("gate pulse while booster idle");
  AST_GATE_SINGLE: assert property (
    gate_pulse_o |=> !gate_pulse_o)
    else $error("gate pulse longer than one cycle");
  // With skipping off every selected edge must come through
  AST_SKIP_OFF_PASS: assert property (
    q.active && q.pulse_skip_level == SKIP_OFF && !q.sync_edge_invert
      && !q.filt[LN_EX] ##1 q.filt[LN_EX] |-> gate_pulse_o)
    else $error("rising edge lost with skipping off");
  AST_FALL_PASS: assert property (
    q.active && q.pulse_skip_level == SKIP_OFF && q.sync_edge_invert
      && q.filt[LN_EX] ##1 !q.filt[LN_EX] |-> gate_pulse_o)
    else $error("falling edge lost with inversion set");
  // Full code puts a margin of seven exactly on the untrimmed limit
  AST_LIMIT_FULL_CODE: assert property (
    q.factory_limit_trim == 4'h0 && q.boost_voltage_target == 7'h7f
      |-> q.limit_ok == (q.overvoltage_shutdown_margin > 4'h7))
    else $error("limit relation wrong at full code");
  // One trim step of either sign moves the limit across that point
  AST_TRIM_SIGN: assert property (
    q.factory_limit_trim[2:0] == 3'h1 && q.boost_voltage_target == 7'h7f
      && q.overvoltage_shutdown_margin == 4'h7
      |-> q.limit_ok == q.factory_limit_trim[3])
    else $error("trim sign applied the wrong way");
  AST_OFF_START: assert property (
    buck_off_start_i[0] |=> q.off_busy[0] && !buck_off_done_o[0])
    else $error("off-time start not taken");
  // Read data must read zero outside the answer cycle
  AST_RDATA_IDLE: assert property (
    !rd_i |=> rdata_o == 16'h0000)
    else $error("read data outside the read cycle");

  COV_START: cover property ($rose(booster_run_o));
  COV_OV_CYCLE: cover property (q.ov_halt ##[1:50] !q.ov_halt);
  COV_FLAG_CLR: cover property ($fell(q.overvoltage_flag));
  COV_OFF_DONE: cover property (buck_off_done_o[0]);
  COV_FALL_GATE: cover property (gate_pulse_o && q.sync_edge_invert);
endmodule
`default_nettype wire

// ===== design/bes_pkg.sv
// Constants and register map of the booster enable supervisor
//
// Summary of operation
// - Run request 0->1 starts the booster, 1->0 stops it.
// - Status flag shows one only while the booster really switches.
// - Overvoltage halts the booster; it resumes below the hysteresis level.
// - Booster stays off unless setpoint plus margin exceeds trimmed maximum.
// - Four-bit factory trim: top bit is sign, low three bits magnitude.
// - Skip level 00 disables skipping; others suppress pulses below threshold.
// - Buck off time varies inversely with LED voltage, scaled by factor.
// - Overvoltage flag latches; read below reactivation level clears it.
// - Sync edge invert resets to 0 (rising); 1 selects falling edge.
package bes_pkg;
  // ------------------------------------------------------------
  // Register bus
  // ------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_SETPT = 8'h01;
  localparam logic [7:0] REG_TOFF  = 8'h02;
  localparam logic [7:0] REG_STAT  = 8'h03;
  localparam logic [7:0] REG_IRQS  = 8'h04;
  localparam logic [7:0] REG_IRQM  = 8'h05;
  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic       EDGE_INV_RST = 1'b0;
  localparam logic [1:0] MP_SEL_RST   = 2'h0;
  localparam logic [1:0] SKIP_OFF     = 2'h0;
  // ------------------------------------------------------------
  // Synchroniser lanes
  // ------------------------------------------------------------
  localparam int unsigned LN_OV = 0;
  localparam int unsigned LN_RE = 1;
  localparam int unsigned LN_EX = 2;
  localparam int unsigned LN_SK = 3;
  // ------------------------------------------------------------
  // Limit relation, decivolts
  // ------------------------------------------------------------
  localparam logic [11:0] SP_BASE_DV  = 12'h28a; // 65.0 V
  localparam logic [11:0] SP_MAX_CODE = 12'h07f; // 127
  localparam logic [11:0] SP_STEP_DV  = 12'h004; // 0.4 V
  localparam logic [11:0] LIM_BASE_DV = 12'h2a6; // 67.8 V
  localparam logic [11:0] TRIM_ST_DV  = 12'h004; // 0.4 V
  localparam logic [11:0] OV_STEP_DV  = 12'h004; // margin lsb
endpackage

// ===== testbench/bes_sync_src.sv
// External sync clock source standing in for the host logic
`timescale 1ns/1ps
`default_nettype none
module bes_sync_src #(
  parameter int unsigned HALF = 5  // half period in core cycles
) (
  input  wire logic core_clk_i,  // core clock
  input  wire logic run_i,       // frame active
  output var  logic clk_o        // sync clock out
);
  int unsigned cnt;
  // host drives sync
  // Stands low outside frames so no stray edge reaches the booster
  always @(posedge core_clk_i) begin
    if (!run_i) begin
      cnt <= 0;
      clk_o <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      clk_o <= ~clk_o;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/bes_booster_supervisor_tb.sv
// Self-checking bench of the booster enable supervisor
`timescale 1ns/1ps
`default_nettype none
module bes_booster_supervisor_tb;
  import bes_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, sync;
  logic        ov = 1'b0, brk = 1'b0, cmpb = 1'b0, sen = 1'b0;
  logic        run, gate, ovf, irq;
  logic [7:0]  addr = 8'h00;
  logic [15:0] wdata = 16'h0000, vled = 16'h0101, rdata, d;
  logic [3:0]  trim = 4'h0;
  logic [1:0]  offs = 2'b00, done, skip, gain, mp;
  int          fails = 0, check_count = 0, cyc = 0, n, t;
  always #50 clk = ~clk;
  bes_sync_src #(.HALF(5)) i_src (.core_clk_i(clk), .run_i(sen), .clk_o(sync));
  // Short off-time scale keeps timer runs brief
  bes_booster_supervisor #(.TSCALE(4)) i_dut (
    .core_clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .ov_trip_i(ov),
    .below_react_i(brk), .comp_below_i(cmpb), .external_phase_clock_i(sync),
    .factory_trim_i(trim), .vled_code_i(vled), .buck_off_start_i(offs),
    .buck_off_done_o(done), .booster_run_o(run), .gate_pulse_o(gate),
    .pulse_skip_level_o(skip), .error_amp_gain_o(gain),
    .multi_phase_select_o(mp), .overvoltage_flag_o(ovf), .irq_o(irq));
  // ----------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------
  task automatic stop_test();
    if (fails == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      fails++;
    end
  endtask
  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Bounded wait, the synchronisers add a few cycles
  task automatic wait_run(input logic v);
    #1;
    for (int i = 0; i < 20 && run !== v; i++) begin
      @(posedge clk);
      #1;
    end
    check(16'(run), 16'(v));
  endtask
  // Four sync periods; n counts pulses, t is the first pulse cycle
  task automatic gates();
    n = 0;
    t = 0;
    sen <= 1'b1;
    for (int i = 1; i <= 50; i++) begin
      @(posedge clk);
      if (i == 40) sen <= 1'b0;
      #1;
      if (gate === 1'b1) begin
        n++;
        if (t == 0) t = i;
      end
    end
  endtask
  task automatic offt(input logic [7:0] v);
    vled[7:0] <= v;
    @(posedge clk);
    offs <= 2'b01;
    @(posedge clk);
    offs <= 2'b00;
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (done[0] !== 1'b1 && n < 200);
  endtask
  // Cycle ceiling against hangs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      stop_test();
    end
  end
  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  initial begin
    do_reset();
    rd_reg(REG_CTRL);
    check(d, 16'h0000);
    check(16'({skip, gain, mp}), 16'h0000);
    // Margin seven at full code lands exactly on the limit
    wr_reg(REG_SETPT, 16'h077f);
    wr_reg(REG_CTRL, 16'h0001);
    wait_run(1'b0);
    rd_reg(REG_STAT);
    check(16'(d[2:0]), 16'h0000);
    wr_reg(REG_SETPT, 16'h087f);
    wait_run(1'b1);
    rd_reg(REG_STAT);
    check(16'(d[2:0]), 16'h0005);
    wr_reg(REG_SETPT, 16'h0f77);
    wait_run(1'b0);
    wr_reg(REG_SETPT, 16'h0f78);
    wait_run(1'b1);
    wr_reg(REG_CTRL, 16'h0000);
    wait_run(1'b0);
    wr_reg(REG_CTRL, 16'h0001);
    wait_run(1'b1);
    gates();
    check(16'(n), 16'h0004);
    check(16'(t <= 11), 16'h0001);
    wr_reg(REG_CTRL, 16'h0003);
    gates();
    check(16'(n), 16'h0004);
    check(16'(t >= 12), 16'h0001);
    cmpb <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      wr_reg(REG_CTRL, 16'(k * 4 + 1));
      gates();
      check(16'(skip), 16'(k));
      check(16'(n), (k == 0) ? 16'h0004 : 16'h0000);
    end
    cmpb <= 1'b0;
    wr_reg(REG_CTRL, 16'h0000);
    gates();
    check(16'(n), 16'h0000);
    wr_reg(REG_CTRL, 16'h0001);
    wait_run(1'b1);
    ov <= 1'b1;
    wait_run(1'b0);
    check(16'({ovf, irq}), 16'h0002);
    rd_reg(REG_STAT);
    rd_reg(REG_STAT);
    check(16'(d[1:0]), 16'h0002);
    ov <= 1'b0;
    brk <= 1'b1;
    wait_run(1'b1);
    rd_reg(REG_STAT);
    check(16'(d[1]), 16'h0001);
    rd_reg(REG_STAT);
    check(16'({d[1], ovf}), 16'h0000);
    wr_reg(REG_IRQM, 16'h0001);
    @(posedge clk);
    #1 check(16'(irq), 16'h0001);
    wr_reg(REG_IRQS, 16'h0001);
    @(posedge clk);
    #1 check(16'(irq), 16'h0000);
    rd_reg(REG_IRQS);
    check(d, 16'h0006);
    // Factor three with scale four gives a sixteen-unit threshold
    wr_reg(REG_TOFF, 16'h0003);
    offt(8'h01);
    check(16'(n >= 16 && n <= 20), 16'h0001);
    check(16'(done), 16'h0001);
    offt(8'h04);
    check(16'(n >= 4 && n <= 8), 16'h0001);
    // Gain and inverted edge must both fall back on reset
    wr_reg(REG_CTRL, 16'h0032);
    #1 check(16'({gain, mp}), 16'h000c);
    // Negative trim lowers the limit by one step
    trim <= 4'h9;
    do_reset();
    #1 check(16'({run, ovf, gain}), 16'h0000);
    rd_reg(REG_CTRL);
    check(d, 16'h0000);
    wr_reg(REG_SETPT, 16'h077f);
    wr_reg(REG_CTRL, 16'h0001);
    wait_run(1'b1);
    rd_reg(REG_STAT);
    check(16'(d[11:8]), 16'h0009);
    stop_test();
  end
endmodule
`default_nettype wire
